// ==== dhw_map.svh ====
`ifndef DHW_MAP_SVH
`define DHW_MAP_SVH

// Serial frame layout, most significant bit first.
`define DHW_WORD_W 24
`define DHW_LAST_BIT 5'h17
`define DHW_FULL_CNT 5'h18
`define DHW_BIT_AB 23
`define DHW_BIT_RW 22
`define DHW_CH_HI 21
`define DHW_CH_LO 16
`define DHW_TG_HI 15
`define DHW_TG_LO 14
`define DHW_DAT_HI 13
`define DHW_DAT_LO 2
`define DHW_HDR_HI 23
`define DHW_HDR_LO 14
`define DHW_PAD 2'h0

// Channel space.
`define DHW_LAST_CH 6'h27
`define DHW_FIRST_CH 6'h00

// Two-wire slave address, pointer and byte layout.
`define DHW_I2C_FIXED 5'h15
`define DHW_BURST_PTR 8'hFF
`define DHW_BYTE_BITS 4'h8
`define DHW_PTR_PAD_HI 7
`define DHW_PTR_PAD_LO 6
`define DHW_HI_AB 7
`define DHW_HI_TG_HI 5
`define DHW_HI_TG_LO 4
`define DHW_HI_DAT_HI 3

`endif

// ==== dhw_pkg.sv ====
package dhw_pkg;

   // One register update towards the channel register file.
   typedef struct packed {
      logic toggleB;
      logic [5:0] chan;
      logic [1:0] target;
      logic [11:0] data;
   } dhw_wr_t;

   // Register selection for a readback.
   typedef struct packed {
      logic [5:0] chan;
      logic [1:0] target;
   } dhw_rd_t;

   // Parallel port pins, sampled as one bundle.
   typedef struct packed {
      logic csN;
      logic wrN;
      logic [5:0] chan;
      logic [1:0] target;
      logic [11:0] data;
   } dhw_par_t;

   typedef enum logic [1:0] {I2C_IDLE, I2C_RECV, I2C_ACK, I2C_SKIP}
      dhw_i2c_st_t;
   typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_HI, PH_LO} dhw_i2c_ph_t;

endpackage : dhw_pkg

// ==== dhw_host_if.sv ====
`include "dhw_map.svh"
// Functional notes
// R1: Serial word with read bit set selects channel and target to read.
// R2: Next frame returns old header in top 10 bits, register in 12 bits.
// R3: Host fetches the read data with an all-zero no-operation frame.
// R4: Readback output bit changes on each rising serial clock edge.
// R5: With clock idling high, first bit appears when frame line falls.
// R6: Host holds the active-low frame line low around the readback frame.
// R7: Two-wire slave works only with serial mode and protocol select high.
// R8: Two-wire side never drives the clock; accepts up to 400 kHz.
// R9: Slave address is 10101 followed by the two strap pin levels.
// R10: SDA fall with SCL high is start, rise is stop; restart continues.
// R11: Each accepted byte is acknowledged by holding SDA low in ninth clock.
// R12: Idle slave waits for start plus own address with write direction.
// R13: Master watches acknowledges and retries failed transfers.
// R14: Single update is address, pointer, two data bytes, then stop.
// R15: Without stop, further pointer and data pairs update more channels.
// R16: Target select bits in the data bytes choose the register.
// R17: Pointer 0xFF starts burst at channel 0, advancing after each pair.
// R18: Burst returns to pointer mode after channel 39; stop ends it.
// R19: Toggle A/B selection is not used in burst mode.
// R20: Interface select low enables parallel port, disables serial ones.
// R21: Store strobe rising with chip select low loads address and data.
// R22: Parallel address selects any one of the 40 channels.
// R23: Parallel data is a straight binary 12-bit word, bit 11 first.
// R24: Serial word is 24 bits: A/B, R/W, channel, target, data, two pad.
// R25: Pointer low six bits name the channel; invalid pointers are ignored.
// R26: Two-wire update commits only after both data bytes are acknowledged.
module dhw_host_if
   import dhw_pkg::*;
(
   // System clock and synchronous reset.
   input wire logic clk_sys,
   input wire logic srst,
   // Mode straps.
   input wire logic interfaceSelectPin,
   input wire logic protoSelectPin,
   input wire logic [1:0] addressStrapPins,
   // Four-wire serial link, clocked by the host.
   input wire logic sclk,
   input wire logic syncN,
   input wire logic serialDataIn,
   output logic serialDataOut,
   // Two-wire bus; SCL is input only.
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Parallel port.
   input wire logic csN,
   input wire logic storeN,
   input wire logic [5:0] channelAddressBits,
   input wire logic [1:0] targetSelectBits,
   input wire logic [11:0] dataWordBits,
   // Channel register file side.
   output logic wrValid,
   output dhw_wr_t wrCmd,
   output logic rdReq,
   output dhw_rd_t rdAddr,
   input wire logic [11:0] rdData
);

   // -----------------------------------------------------------------
   // Shared helpers
   // -----------------------------------------------------------------

   // Only channels 0 to 39 exist; writes to higher codes are dropped, serial reads are not checked.
   function automatic logic chanValid(input logic [5:0] ch);
      chanValid = (ch <= `DHW_LAST_CH);
   endfunction : chanValid

   // Picks a frame bit by the count of bits already shifted.
   function automatic logic frameBit(input logic [23:0] w,
                                     input logic [4:0] cnt);
      frameBit = (cnt > `DHW_LAST_BIT) ? 1'b0 : w[`DHW_LAST_BIT - cnt];
   endfunction : frameBit

   // -----------------------------------------------------------------
   // Mode straps
   // -----------------------------------------------------------------

   logic [1:0] ifSelS_q, protoS_q, strapS_q, strapS2_q;
   logic modeSpi, modeI2c, modePar;

   // Straps come from pins, so they pass two flops first.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ifSelS_q <= 2'h0;
         protoS_q <= 2'h0;
         strapS_q <= 2'h0;
         strapS2_q <= 2'h0;
      end else begin
         ifSelS_q <= {ifSelS_q[0], interfaceSelectPin};
         protoS_q <= {protoS_q[0], protoSelectPin};
         strapS_q <= addressStrapPins;
         strapS2_q <= strapS_q;
      end
   end

   // Exactly one interface is live at a time.
   assign modePar = ~ifSelS_q[1]; // see R20
   assign modeSpi = ifSelS_q[1] & ~protoS_q[1];
   assign modeI2c = ifSelS_q[1] & protoS_q[1]; // see R7

   // -----------------------------------------------------------------
   // Serial link, host clock domain
   // -----------------------------------------------------------------

   logic [4:0] fallCnt_q;
   logic [22:0] inShift_q;
   logic [23:0] inWord_q, rbWord_q;
   logic frameTgl_q, outBit_q;

   // The frame line clears the bit count, so a short frame is dropped.
   always_ff @(negedge sclk or posedge syncN) begin
      if (syncN) begin
         fallCnt_q <= 5'h00;
      end else if (fallCnt_q != `DHW_FULL_CNT) begin
         fallCnt_q <= fallCnt_q + 5'h01;
      end
   end

   // Bits enter on falling edges; the 24th completes the held word.
   always_ff @(negedge sclk) begin
      if (!syncN && fallCnt_q < `DHW_LAST_BIT) begin
         inShift_q <= {inShift_q[21:0], serialDataIn}; // see R24
      end else if (!syncN && fallCnt_q == `DHW_LAST_BIT) begin
         inWord_q <= {inShift_q, serialDataIn};
      end
   end

   // Frame completion crosses to the system side as a toggle.
   always_ff @(negedge sclk or posedge srst) begin
      if (srst) begin
         frameTgl_q <= 1'b0;
      end else if (!syncN && fallCnt_q == `DHW_LAST_BIT) begin
         frameTgl_q <= ~frameTgl_q;
      end
   end

   // Next readback bit is launched on each rising edge.
   always_ff @(posedge sclk) begin
      outBit_q <= frameBit(rbWord_q, fallCnt_q); // see R4
   end

   // Before the first fall the top bit shows directly, covering a clock
   // resting high; the word is static for the frame, so this is safe.
   always_comb begin
      if (syncN || !modeSpi) begin
         serialDataOut = 1'b0;
      end else if (fallCnt_q == 5'h00) begin
         serialDataOut = rbWord_q[`DHW_BIT_AB]; // see R5
      end else begin
         serialDataOut = outBit_q;
      end
   end

   // -----------------------------------------------------------------
   // Serial link, system side
   // -----------------------------------------------------------------

   logic [2:0] frameS_q;
   logic [9:0] rbHdr_q;
   logic frameEv, isRead, isNoOp, rdPend_q;

   // Toggle synchroniser; only the later stages feed the edge detect.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         frameS_q <= 3'h0;
      end else begin
         frameS_q <= {frameS_q[1:0], frameTgl_q};
      end
   end

   assign frameEv = (frameS_q[1] ^ frameS_q[2]) & modeSpi;
   assign isRead = inWord_q[`DHW_BIT_RW]; // see R1
   assign isNoOp = (inWord_q == {`DHW_WORD_W{1'b0}});

   // Read request follows the frame; register data comes a cycle later.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdReq <= 1'b0;
         rdPend_q <= 1'b0;
         rdAddr <= '0;
         rbHdr_q <= 10'h000;
      end else begin
         rdReq <= frameEv & isRead;
         rdPend_q <= rdReq;
         if (frameEv && isRead) begin
            rdAddr <= inWord_q[`DHW_CH_HI:`DHW_TG_LO]; // see R1
            rbHdr_q <= inWord_q[`DHW_HDR_HI:`DHW_HDR_LO];
         end
      end
   end

   // A finished frame consumes the readback word; a read arms a new one.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rbWord_q <= 24'h000000;
      end else if (rdPend_q) begin
         rbWord_q <= {rbHdr_q, rdData, `DHW_PAD}; // see R2
      end else if (frameEv) begin
         rbWord_q <= 24'h000000;
      end
   end

   // -----------------------------------------------------------------
   // Two-wire slave
   // -----------------------------------------------------------------

   logic [2:0] sclS_q, sdaS_q;
   logic sclRise, sclFall, startCond, stopCond, byteDone, addrHit, ackNow;
   dhw_i2c_st_t st_q;
   dhw_i2c_ph_t ph_q;
   logic [3:0] bitCnt_q;
   logic [7:0] shift_q, hi_q;
   logic [5:0] chan_q;
   logic chanOk_q, burst_q, i2cPend_q, i2cCommit;
   dhw_wr_t i2cCmd_q;

   // Bus lines pass two flops; the third stage is the previous level.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sclS_q <= 3'h7;
         sdaS_q <= 3'h7;
      end else begin
         sclS_q <= {sclS_q[1:0], scl};
         sdaS_q <= {sdaS_q[1:0], sdaIn};
      end
   end

   // The 100 MHz sampling leaves wide margin at 400 kHz bus clocks.
   assign sclRise = sclS_q[1] & ~sclS_q[2]; // see R8
   assign sclFall = ~sclS_q[1] & sclS_q[2];
   assign startCond = sclS_q[1] & sclS_q[2] & ~sdaS_q[1] & sdaS_q[2];
   assign stopCond = sclS_q[1] & sclS_q[2] & sdaS_q[1] & ~sdaS_q[2];
   assign byteDone = (st_q == I2C_RECV) && sclFall &&
                     (bitCnt_q == `DHW_BYTE_BITS);
   // Only a write-direction address is ours; reads get no acknowledge.
   assign addrHit = (shift_q[7:1] == {`DHW_I2C_FIXED, strapS2_q}) &&
                    !shift_q[0]; // see R9
   assign ackNow = (ph_q == PH_ADDR) ? addrHit : 1'b1; // see R12

   // Bit and acknowledge sequencing.
   always_ff @(posedge clk_sys) begin
      if (srst || !modeI2c) begin
         st_q <= I2C_IDLE;
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
      end else if (startCond) begin
         st_q <= I2C_RECV; // see R10
         bitCnt_q <= 4'h0;
      end else if (stopCond) begin
         st_q <= I2C_IDLE; // see R10
      end else begin
         unique case (st_q)
            I2C_IDLE: st_q <= I2C_IDLE; // see R12
            I2C_RECV: begin
               if (sclRise && bitCnt_q < `DHW_BYTE_BITS) begin
                  shift_q <= {shift_q[6:0], sdaS_q[1]};
                  bitCnt_q <= bitCnt_q + 4'h1;
               end else if (byteDone) begin
                  st_q <= ackNow ? I2C_ACK : I2C_SKIP;
               end
            end
            I2C_ACK: begin
               if (sclFall) begin // Release once the ninth clock falls.
                  st_q <= I2C_RECV; // see R11
                  bitCnt_q <= 4'h0;
               end
            end
            I2C_SKIP: st_q <= I2C_SKIP;
         endcase
      end
   end

   // SDA is open drain: pulled low only during the acknowledge clock.
   assign sdaOut = 1'b0;
   assign sdaOe = (st_q == I2C_ACK); // see R11

   // Byte meaning: address, pointer, then data pairs.
   always_ff @(posedge clk_sys) begin
      if (srst || startCond || !modeI2c) begin
         ph_q <= PH_ADDR; // see R10
         burst_q <= 1'b0;
         chanOk_q <= 1'b0;
         chan_q <= `DHW_FIRST_CH;
         hi_q <= 8'h00;
      end else if (stopCond) begin
         ph_q <= PH_ADDR; // see R15
         burst_q <= 1'b0; // see R18
      end else if (byteDone && ackNow) begin
         unique case (ph_q)
            PH_ADDR: ph_q <= PH_PTR; // see R14
            PH_PTR: begin
               ph_q <= PH_HI;
               if (shift_q == `DHW_BURST_PTR) begin
                  burst_q <= 1'b1; // see R17
                  chan_q <= `DHW_FIRST_CH;
                  chanOk_q <= 1'b1;
               end else begin
                  chan_q <= shift_q[5:0]; // see R25
                  chanOk_q <= chanValid(shift_q[5:0]) &&
                     (shift_q[`DHW_PTR_PAD_HI:`DHW_PTR_PAD_LO] == 2'h0);
               end
            end
            PH_HI: begin
               hi_q <= shift_q;
               ph_q <= PH_LO;
            end
            PH_LO: begin
               if (!burst_q) begin
                  ph_q <= PH_PTR; // see R15
               end else if (chan_q == `DHW_LAST_CH) begin
                  burst_q <= 1'b0; // see R18
                  ph_q <= PH_PTR;
               end else begin
                  chan_q <= chan_q + 6'h01; // see R17
                  ph_q <= PH_HI;
               end
            end
         endcase
      end
   end

   // A pair waits for its acknowledge to end; start or stop discards it.
   always_ff @(posedge clk_sys) begin
      if (srst || startCond || stopCond || !modeI2c) begin
         i2cPend_q <= 1'b0; // see R26
         i2cCmd_q <= '0;
      end else if (byteDone && ph_q == PH_LO && chanOk_q) begin
         i2cPend_q <= 1'b1;
         i2cCmd_q.toggleB <= hi_q[`DHW_HI_AB] & ~burst_q; // see R19
         i2cCmd_q.chan <= chan_q;
         i2cCmd_q.target <= hi_q[`DHW_HI_TG_HI:`DHW_HI_TG_LO]; // see R16
         i2cCmd_q.data <= {hi_q[`DHW_HI_DAT_HI:0], shift_q};
      end else if (i2cCommit) begin
         i2cPend_q <= 1'b0;
      end
   end

   assign i2cCommit = i2cPend_q && (st_q == I2C_ACK) && sclFall; // see R26

   // -----------------------------------------------------------------
   // Parallel port
   // -----------------------------------------------------------------

   dhw_par_t parS1_q, parS2_q;
   logic prevStoreN_q, parCommit;

   // Strobe and bus are sampled together so they stay aligned.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         parS1_q <= '1;
         parS2_q <= '1;
         prevStoreN_q <= 1'b1;
      end else begin
         parS1_q <= {csN, storeN, channelAddressBits, targetSelectBits,
                     dataWordBits};
         parS2_q <= parS1_q;
         prevStoreN_q <= parS2_q.wrN;
      end
   end

   // Host must hold data a few system clocks past the strobe edge.
   assign parCommit = modePar && parS2_q.wrN && !prevStoreN_q &&
                      !parS2_q.csN && chanValid(parS2_q.chan); // see R21

   // -----------------------------------------------------------------
   // Write port to the channel registers
   // -----------------------------------------------------------------

   // Interfaces are mutually exclusive by mode, so no source collides.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wrValid <= 1'b0;
         wrCmd <= '0;
      end else begin
         wrValid <= 1'b0;
         if (frameEv && !isRead && !isNoOp &&
             chanValid(inWord_q[`DHW_CH_HI:`DHW_CH_LO])) begin
            wrValid <= 1'b1; // see R24
            wrCmd <= {inWord_q[`DHW_BIT_AB],
                      inWord_q[`DHW_CH_HI:`DHW_DAT_LO]};
         end else if (i2cCommit) begin
            wrValid <= 1'b1; // see R14
            wrCmd <= i2cCmd_q;
         end else if (parCommit) begin
            wrValid <= 1'b1; // see R22
            wrCmd.toggleB <= 1'b0;
            wrCmd.chan <= parS2_q.chan;
            wrCmd.target <= parS2_q.target;
            wrCmd.data <= parS2_q.data; // see R23
         end
      end
   end

endmodule : dhw_host_if

// ==== dhw_host_if_asserts.sv ====
// ----------------------------------------
// Port checker for the host interface.
// ----------------------------------------
module dhw_host_if_asserts
   import dhw_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // Straps and host lines.
   input wire logic interfaceSelectPin,
   input wire logic protoSelectPin,
   input wire logic syncN,
   input wire logic scl,
   // Outputs under watch.
   input wire logic serialDataOut,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic wrValid,
   input wire dhw_wr_t wrCmd,
   input wire logic rdReq,
   input wire dhw_rd_t rdAddr
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   // Mode lines held long enough to pass the synchroniser.
   sequence parMode;
      !interfaceSelectPin [*6];
   endsequence
   sequence notTwoWire;
      !(interfaceSelectPin && protoSelectPin) [*6];
   endsequence
   // The acknowledge starts in the low phase and is held for at least eight cycles.
   sequence ackHeld;
      !scl ##0 sdaOe [*8];
   endsequence

   chk_open_drain: assert property (sdaOut == 1'b0)
      else $error("data line driven high");
   chk_wr_single: assert property (wrValid |=> !wrValid)
      else $error("write pulse too long");
   chk_rd_single: assert property (rdReq |=> !rdReq)
      else $error("read pulse too long");
   chk_wr_held: assert property ($changed(wrCmd) |-> wrValid)
      else $error("write command moved without a pulse");
   chk_rd_held: assert property ($changed(rdAddr) |-> rdReq)
      else $error("read address moved without a pulse");
   chk_chan_limit: assert property (wrValid |-> wrCmd.chan <= 6'h27)
      else $error("write to a channel beyond the last");
   chk_ack_start: assert property ($rose(sdaOe) |-> ackHeld)
      else $error("acknowledge badly placed");
   chk_ack_release: assert property ($fell(sdaOe) |-> !scl)
      else $error("acknowledge released with clock high");
   chk_par_quiet: assert property (parMode |->
      !sdaOe && !rdReq && !serialDataOut)
      else $error("serial side active in parallel mode");
   chk_two_wire_mode: assert property (notTwoWire |-> !sdaOe)
      else $error("two-wire acknowledge outside its mode");
   chk_sdo_idle: assert property (syncN [*2] |-> !serialDataOut)
      else $error("readback output active outside a frame");
endmodule : dhw_host_if_asserts

bind dhw_host_if dhw_host_if_asserts chk (
   .clk_sys(clk_sys), .srst(srst),
   .interfaceSelectPin(interfaceSelectPin),
   .protoSelectPin(protoSelectPin), .syncN(syncN), .scl(scl),
   .serialDataOut(serialDataOut), .sdaOut(sdaOut), .sdaOe(sdaOe),
   .wrValid(wrValid), .wrCmd(wrCmd), .rdReq(rdReq), .rdAddr(rdAddr)
);

// ==== dhw_host_model.sv ====
// ----------------------------------------
// Host model: four-wire master and two-wire master.
// ----------------------------------------
module dhw_host_model (
   // Four-wire link.
   output logic sclk,
   output logic syncN,
   output logic serialDataIn,
   input wire logic serialDataOut,
   // Two-wire bus; sdaPull high pulls the wire low.
   output logic scl,
   output logic sdaPull,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   // Half period of the bus clock; raise it for a slow master.
   int sclHalf = 200;

   // Both links idle with the clocks standing high.
   initial begin
      sclk = 1'b1;
      syncN = 1'b1;
      serialDataIn = 1'b0;
      scl = 1'b1;
      sdaPull = 1'b0;
   end

   // Sends the top n bits of w and samples readback on falling edges.
   task automatic frame(input logic [23:0] w, input int n,
         output logic [23:0] rx);
      #3 syncN = 1'b0;
      serialDataIn = w[23];
      #40;
      for (int i = 23; i > 23 - n; i--) begin
         sclk = 1'b0;
         rx[i] = serialDataOut;
         #40 sclk = 1'b1;
         #5 serialDataIn = w[(i > 0) ? i - 1 : 0];
         #35;
      end
      syncN = 1'b1;
      serialDataIn = ~serialDataIn; // The data line is flipped, not held, once the frame ends.
      #300;
   endtask : frame

   // Start or repeated start, leaving the clock low.
   task automatic i2cStart();
      #3 sdaPull = 1'b0;
      #(sclHalf / 2) scl = 1'b1;
      #(sclHalf / 2) sdaPull = 1'b1;
      #(sclHalf / 2) scl = 1'b0;
   endtask : i2cStart

   task automatic i2cStop();
      sdaPull = 1'b1;
      #(sclHalf / 2) scl = 1'b1;
      #(sclHalf / 2) sdaPull = 1'b0;
      #(sclHalf);
   endtask : i2cStop

   // One byte out, then the acknowledge is read mid-high.
   task automatic i2cByte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #(sclHalf / 2) sdaPull = ~b[i];
         #(sclHalf / 2) scl = 1'b1;
         #(sclHalf) scl = 1'b0;
      end
      #(sclHalf / 2) sdaPull = 1'b0;
      #(sclHalf / 2) scl = 1'b1;
      #(sclHalf / 2) ack = sda;
      #(sclHalf / 2) scl = 1'b0;
   endtask : i2cByte
endmodule : dhw_host_model

// ==== dhw_host_if_tb.sv ====
module dhw_host_if_tb
   import dhw_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, srst, interfaceSelectPin, protoSelectPin;
   logic [1:0] addressStrapPins, targetSelectBits;
   logic sclk, syncN, serialDataIn, serialDataOut, scl, sda, sdaPull;
   logic sdaOut, sdaOe, csN, storeN, wrValid, rdReq;
   logic [5:0] channelAddressBits;
   logic [11:0] dataWordBits, rdData;
   dhw_wr_t wrCmd;
   dhw_rd_t rdAddr;
   dhw_wr_t wrQ[$];
   dhw_rd_t rdQ[$];
   logic [23:0] rx, rq;
   int failures = 0;
   int samplesChecked = 0;
   int cycles = 0;

   // The wire has a pull-up; either party may pull it low.
   assign sda = ((sdaOe && !sdaOut) || sdaPull) ? 1'b0 : 1'b1;

   dhw_host_if dut (.clk_sys(clk_sys), .srst(srst),
      .interfaceSelectPin(interfaceSelectPin),
      .protoSelectPin(protoSelectPin), .addressStrapPins(addressStrapPins),
      .sclk(sclk), .syncN(syncN), .serialDataIn(serialDataIn),
      .serialDataOut(serialDataOut), .scl(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .csN(csN), .storeN(storeN),
      .channelAddressBits(channelAddressBits),
      .targetSelectBits(targetSelectBits), .dataWordBits(dataWordBits),
      .wrValid(wrValid), .wrCmd(wrCmd), .rdReq(rdReq), .rdAddr(rdAddr),
      .rdData(rdData));
   dhw_host_model host (.sclk(sclk), .syncN(syncN),
      .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
      .scl(scl), .sdaPull(sdaPull), .sda(sda));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Collects outputs, serves reads a cycle late, and bounds the run.
   always @(posedge clk_sys) begin
      if (wrValid === 1'b1) wrQ.push_back(wrCmd);
      if (rdReq === 1'b1) rdQ.push_back(rdAddr);
      rdData <= (rdReq === 1'b1) ? {4'h5, rdAddr} : ~rdData;
      cycles++;
      if (cycles == 80000) begin
         failures++;
         finish_test();
      end
   end

   task automatic checkVal(input logic [23:0] got, input logic [23:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : checkVal

   // Waits a bounded time for the next write and compares it whole.
   task automatic checkWr(input dhw_wr_t exp);
      dhw_wr_t got;
      for (int n = 0; n < 500 && wrQ.size() == 0; n++) @(posedge clk_sys);
      if (wrQ.size() > 0) got = wrQ.pop_front();
      checkVal(got, exp);
   endtask : checkWr

   // Nothing unexpected may remain once a scenario ends.
   task automatic endScenario(input string name);
      repeat (30) @(posedge clk_sys);
      checkVal(wrQ.size(), 24'h0);
      checkVal(rdQ.size(), 24'h0);
      $display("test %s done", name);
   endtask : endScenario

   task automatic setMode(input logic ser, input logic proto);
      @(posedge clk_sys);
      interfaceSelectPin <= ser;
      protoSelectPin <= proto;
      repeat (6) @(posedge clk_sys);
   endtask : setMode

   // Sends n left-aligned bytes of b; acks return left aligned.
   task automatic i2cSend(input logic [31:0] b, input int n,
         input logic [3:0] expAck);
      logic [3:0] got;
      logic a;
      got = 4'h0;
      for (int k = 0; k < n; k++) begin
         host.i2cByte(b[31 - 8 * k -: 8], a);
         got[3 - k] = a;
      end
      checkVal(got, expAck);
   endtask : i2cSend

   task automatic parWrite(input logic cs, input logic [5:0] ch,
         input logic [1:0] tg, input logic [11:0] d);
      @(posedge clk_sys);
      csN <= cs;
      channelAddressBits <= ch;
      targetSelectBits <= tg;
      dataWordBits <= d;
      storeN <= 1'b0;
      repeat (4) @(posedge clk_sys);
      storeN <= 1'b1;
      repeat (4) @(posedge clk_sys);
      csN <= 1'b1;
      dataWordBits <= ~d;
   endtask : parWrite

   task automatic testSerialWrite();
      logic a;
      setMode(1'b1, 1'b0);
      host.frame({2'b10, 6'h07, 2'h2, 12'hABC, 2'h3}, 24, rx);
      checkWr({1'b1, 6'h07, 2'h2, 12'hABC});
      host.frame({2'b00, 6'h27, 2'h1, 12'h001, 2'h0}, 24, rx);
      checkWr({1'b0, 6'h27, 2'h1, 12'h001});
      host.frame({2'b00, 6'h28, 2'h0, 12'h123, 2'h0}, 24, rx);
      host.frame(24'h4A5A5A, 20, rx);
      host.i2cStart();
      host.i2cByte(8'hAC, a);
      host.i2cStop();
      checkVal(a, 24'h1);
      endScenario("serial write");
   endtask : testSerialWrite

   task automatic testReadback();
      rq = {2'b01, 6'h03, 2'h1, 12'hFFF, 2'h0};
      host.frame(rq, 24, rx);
      repeat (10) @(posedge clk_sys);
      checkVal(rdQ.size(), 24'h1);
      if (rdQ.size() == 1) checkVal(rdQ.pop_front(), 24'h0D);
      host.frame(24'h0, 24, rx);
      checkVal(rx, {rq[23:14], 12'h50D, 2'h0});
      endScenario("readback");
   endtask : testReadback

   task automatic testTwoWire();
      setMode(1'b1, 1'b1);
      host.i2cStart();
      i2cSend(32'hAC05B35A, 4, 4'h0);
      checkWr({1'b1, 6'h05, 2'h3, 12'h35A});
      i2cSend(32'h06123400, 3, 4'h0);
      checkWr({1'b0, 6'h06, 2'h1, 12'h234});
      host.i2cStart();
      i2cSend(32'hAC288FFF, 4, 4'h0);
      i2cSend(32'h02410000, 2, 4'h0);
      host.i2cStop();
      host.i2cStart();
      i2cSend(32'hAE010000, 2, 4'hC);
      host.i2cStart();
      i2cSend(32'hAD000000, 1, 4'h8);
      host.i2cStop();
      endScenario("two-wire");
   endtask : testTwoWire

   task automatic testBurst();
      logic [5:0] c;
      logic [7:0] lo;
      @(posedge clk_sys);
      addressStrapPins <= 2'h1;
      repeat (4) @(posedge clk_sys);
      host.i2cStart();
      i2cSend(32'hAAFF0000, 2, 4'h0);
      for (int ch = 0; ch < 40; ch++) begin
         c = ch[5:0];
         lo = {2'h0, c} ^ 8'h5A;
         i2cSend({2'b10, 2'h2, c[3:0], lo, 16'h0}, 2, 4'h0);
         checkWr({1'b0, c, 2'h2, c[3:0], lo});
      end
      i2cSend(32'h09012300, 3, 4'h0);
      checkWr({1'b0, 6'h09, 2'h0, 12'h123});
      host.i2cStop();
      endScenario("burst");
   endtask : testBurst

   task automatic testParallel();
      logic a;
      setMode(1'b0, 1'b1);
      parWrite(1'b0, 6'h27, 2'h2, 12'h801);
      checkWr({1'b0, 6'h27, 2'h2, 12'h801});
      parWrite(1'b0, 6'h00, 2'h1, 12'hFFE);
      checkWr({1'b0, 6'h00, 2'h1, 12'hFFE});
      parWrite(1'b1, 6'h01, 2'h1, 12'h555);
      parWrite(1'b0, 6'h28, 2'h1, 12'h555);
      host.frame({2'b00, 6'h02, 2'h1, 12'h321, 2'h0}, 24, rx);
      host.i2cStart();
      host.i2cByte(8'hAA, a);
      host.i2cStop();
      checkVal(a, 24'h1);
      endScenario("parallel");
   endtask : testParallel

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   // Main sequence: reset, then every scenario in turn.
   initial begin
      srst = 1'b1;
      interfaceSelectPin = 1'b1;
      protoSelectPin = 1'b0;
      addressStrapPins = 2'h2;
      csN = 1'b1;
      storeN = 1'b1;
      channelAddressBits = 6'h00;
      targetSelectBits = 2'h0;
      dataWordBits = 12'h000;
      rdData = 12'h000;
      repeat (20) @(posedge clk_sys);
      checkVal({wrCmd, wrValid, rdReq, sdaOe}, 24'h0);
      checkVal({rdAddr, serialDataOut}, 24'h0);
      srst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      testSerialWrite();
      testReadback();
      testTwoWire();
      testBurst();
      testParallel();
      finish_test();
   end
endmodule : dhw_host_if_tb
